// [tca_regs.svh]
// Register offsets, field positions and reset values of the time and calendar keeper
`ifndef TCA_REGS_SVH
`define TCA_REGS_SVH
// Byte offsets on the register bus
`define TCA_OFS_MODE 8'h00
`define TCA_OFS_HMODE 8'h04
`define TCA_OFS_TIME 8'h08
`define TCA_OFS_CAL 8'h0C
`define TCA_OFS_TALM 8'h10
`define TCA_OFS_CALM 8'h14
`define TCA_OFS_STAT 8'h18
`define TCA_OFS_SCLR 8'h1C
// Mode register fields
`define TCA_STOPT_BIT 0
`define TCA_STOPC_BIT 1
`define TCA_TIME_EVENT_SELECTOR_RNG 9:8
`define TCA_CALENDAR_EVENT_SELECTOR_RNG 17:16
// Time and time alarm fields
`define TCA_SEC_RNG 6:0
`define TCA_SECOND_MATCH_ENABLE_BIT 7
`define TCA_MIN_RNG 14:8
`define TCA_MINUTE_MATCH_ENABLE_BIT 15
`define TCA_HOUR_RNG 21:16
`define TCA_MER_BIT 22
`define TCA_HOUR_MATCH_ENABLE_BIT 23
// Calendar and calendar alarm fields
`define TCA_CENTURY_FIELD_RNG 6:0
`define TCA_YEAR_RNG 15:8
`define TCA_MONTH_RNG 20:16
`define TCA_DAY_RNG 23:21
`define TCA_DATE_RNG 29:24
`define TCA_MONTH_MATCH_ENABLE_BIT 23
`define TCA_DATE_MATCH_ENABLE_BIT 31
// Status bits
`define TCA_ST_ACK 0
`define TCA_ST_ALARM 1
`define TCA_ST_SEC 2
`define TCA_ST_TIME_EVENT_FLAG 3
`define TCA_ST_CALENDAR_EVENT_FLAG 4
`define TCA_ST_W 5
// Reset values
`define TCA_CAL_RST 32'h0181_9819
`define TCA_ZERO32 32'h0000_0000
// BCD figures used by the counters
`define TCA_B59 8'h59
`define TCA_B23 8'h23
`define TCA_B12 8'h12
`define TCA_B11 8'h11
`define TCA_B01 8'h01
`define TCA_B02 8'h02
`define TCA_B99 8'h99
`define TCA_B28 8'h28
`define TCA_B29 8'h29
`define TCA_B30 8'h30
`define TCA_B31 8'h31
`define TCA_B04 8'h04
`define TCA_B06 8'h06
`define TCA_B09 8'h09
`define TCA_B00 8'h00
`define TCA_DAY_LAST 3'h7
`define TCA_DAY_FIRST 3'h1
`define TCA_DAY_WEEK 3'h1
`endif

// [tca_pkg.sv]
// Types shared by the time and calendar keeper
package tca_pkg;
  typedef enum logic [1:0] {TEV_MINUTE, TEV_HOUR, TEV_MIDNIGHT, TEV_NOON} tca_tev_t;
  typedef enum logic [1:0] {CEV_WEEK, CEV_MONTH, CEV_YEAR, CEV_RSVD} tca_cev_t;
  typedef struct packed {
    logic meridiem;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } tca_time_t;
  typedef struct packed {
    logic [7:0] date;
    logic [2:0] day;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] century;
  } tca_cal_t;
endpackage : tca_pkg

// [tca_time_keeper.sv]
// APB time-of-day, calendar and alarm keeper
//
// Operation
// (RL1) Hour format bit: 0 counts 24 hours, 1 counts 12 hours with meridiem.
// (RL2) Seconds are BCD 0 to 59, units low nibble, tens above.
// (RL3) Minutes are BCD 0 to 59, units low nibble, tens above.
// (RL4) Hours are BCD 1 to 12 in 12-hour form, 0 to 23 otherwise.
// (RL5) Meridiem bit 22 of the time register: 0 morning, 1 afternoon.
// (RL6) Software writes meridiem as 0 in time and alarm when 24-hour form.
// (RL7) Century is BCD 19 to 20.
// (RL8) Year is BCD 00 to 99.
// (RL9) Month is BCD 01 to 12.
// (RL10) Weekday 1 to 7 cycles alone and never steers the date counter.
// (RL11) Date of month is BCD 01 to 31.
// (RL12) Calendar resets to 0x01819819; format, time, alarms, status reset to zero.
// (RL13) Second, minute, hour alarm compares count only while enables 7, 15, 23 set.
// (RL14) Month and date alarm compares count only while enables 23, 31 set.
// (RL15) Each alarm field compares against its BCD running counter, hour with meridiem.
// (RL16) Update acknowledge reads 1 only when time and calendar may be written.
// (RL17) Alarm flag sets on a match and holds until software clears it.
// (RL18) Second flag sets each tick and holds until cleared.
// (RL19) Time event flag is sticky, set on selected minute, hour, noon, midnight.
// (RL20) Calendar event flag is sticky, set on selected week, month, year change.
// (RL21) Time codes 0-3: minute, hour, midnight, noon; calendar 0-2: week, month, year.
// (RL22) Update: set stop, await acknowledge, clear it, write, clear stop, resume.
// (RL23) Writing 1 to a status clear bit clears that flag; 0 does nothing.
// (RL24) Alarm sets when all enabled fields match together; none enabled, no alarm.
// (RL25) Counters carry in BCD through all fields with month length and leap years.
// (RL26) 12-hour form goes 11 to 12 toggling meridiem, then 12 to 1.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`include "tca_regs.svh"
module tca_time_keeper (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // One-second tick, one cycle wide
  input wire logic secTick,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // BCD increment of a two-digit value
  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcdInc = {v[7:4] + 4'h1, 4'h0};
    else
      bcdInc = {v[7:4], v[3:0] + 4'h1};
  endfunction : bcdInc

  // Leap test on a BCD pair: divisible by four
  function automatic logic bcdDiv4(input logic [7:0] v);
    if (v[4])
      bcdDiv4 = (v[3:0] == 4'h2) || (v[3:0] == 4'h6);
    else
      bcdDiv4 = (v[3:0] == 4'h0) || (v[3:0] == 4'h4) || (v[3:0] == 4'h8);
  endfunction : bcdDiv4

  // Register select, shared by read and write paths
  function automatic logic isReg(input logic [7:0] a, input logic [7:0] ofs);
    isReg = (a == ofs);
  endfunction : isReg

  ////////////////////////////////////////////////////////////////////////////////
  // State

  // Named copy of the calendar reset word, so its fields can be sliced
  localparam logic [31:0] calRst = `TCA_CAL_RST;

  logic stopTime_r;
  logic stopCal_r;
  tca_pkg::tca_tev_t time_event_selector_r;
  tca_pkg::tca_cev_t calendar_event_selector_r;
  logic hourMode_r;
  tca_pkg::tca_time_t time_r, time_nxt;
  tca_pkg::tca_cal_t cal_r, cal_nxt;
  logic [31:0] talm_r;
  logic [31:0] calm_r;
  logic [`TCA_ST_W-1:0] status_r, status_nxt;
  logic ackPend_r;
  logic matchPrev_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  logic wrEn;
  logic setupRd;
  logic known;
  logic [`TCA_ST_W-1:0] setBits;
  logic [`TCA_ST_W-1:0] clrBits;
  logic minCarry, hourCarry, dayCarry, monCarry, yearCarry, noonHit;
  logic alarmMatch, anyEn;
  logic [7:0] lastDate;
  logic [31:0] timeWord, calWord;

  assign wrEn = psel && penable && pwrite && pready_r;
  assign setupRd = psel && !penable;
  assign known = (paddr[7:5] == 3'h0);

  // Pack running counters into their register images
  always_comb
  begin
    timeWord = `TCA_ZERO32;
    timeWord[`TCA_SEC_RNG] = time_r.second[6:0];
    timeWord[`TCA_MIN_RNG] = time_r.minute[6:0];
    timeWord[`TCA_HOUR_RNG] = time_r.hour[5:0];
    timeWord[`TCA_MER_BIT] = time_r.meridiem; // see (RL5)
    calWord = `TCA_ZERO32;
    calWord[`TCA_CENTURY_FIELD_RNG] = cal_r.century[6:0];
    calWord[`TCA_YEAR_RNG] = cal_r.year;
    calWord[`TCA_MONTH_RNG] = cal_r.month[4:0];
    calWord[`TCA_DAY_RNG] = cal_r.day;
    calWord[`TCA_DATE_RNG] = cal_r.date[5:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Month length, leap years by year or by century at year 00

  always_comb
  begin
    if (cal_r.month == `TCA_B02)
    begin
      if (cal_r.year == `TCA_B00)
        lastDate = bcdDiv4(cal_r.century) ? `TCA_B29 : `TCA_B28; // see (RL25)
      else
        lastDate = bcdDiv4(cal_r.year) ? `TCA_B29 : `TCA_B28;
    end
    else if ((cal_r.month == `TCA_B04) || (cal_r.month == `TCA_B06) ||
             (cal_r.month == `TCA_B09) || (cal_r.month == `TCA_B11))
      lastDate = `TCA_B30;
    else
      lastDate = `TCA_B31;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter advance; weekday never feeds the date chain

  always_comb
  begin
    time_nxt = time_r;
    cal_nxt = cal_r;
    minCarry = 1'b0;
    hourCarry = 1'b0;
    dayCarry = 1'b0;
    monCarry = 1'b0;
    yearCarry = 1'b0;
    noonHit = 1'b0;
    if (secTick && !stopTime_r)
    begin
      if (time_r.second == `TCA_B59) // see (RL2)
      begin
        time_nxt.second = `TCA_B00;
        minCarry = 1'b1;
      end
      else
        time_nxt.second = bcdInc(time_r.second);
      if (minCarry)
      begin
        if (time_r.minute == `TCA_B59) // see (RL3)
        begin
          time_nxt.minute = `TCA_B00;
          hourCarry = 1'b1;
        end
        else
          time_nxt.minute = bcdInc(time_r.minute);
      end
      if (hourCarry)
      begin
        if (hourMode_r) // see (RL1)
        begin
          if (time_r.hour == `TCA_B11) // see (RL26)
          begin
            time_nxt.hour = `TCA_B12;
            time_nxt.meridiem = !time_r.meridiem;
            dayCarry = time_r.meridiem;
            noonHit = !time_r.meridiem;
          end
          else if (time_r.hour == `TCA_B12) // see (RL4)
            time_nxt.hour = `TCA_B01;
          else
            time_nxt.hour = bcdInc(time_r.hour);
        end
        else if (time_r.hour == `TCA_B23) // see (RL4)
        begin
          time_nxt.hour = `TCA_B00;
          dayCarry = 1'b1;
        end
        else
        begin
          time_nxt.hour = bcdInc(time_r.hour);
          noonHit = (time_r.hour == `TCA_B11);
        end
      end
    end
    // Calendar follows the day carry only while its own counting runs
    if (dayCarry && !stopCal_r) // see (RL25)
    begin
      cal_nxt.day = (cal_r.day == `TCA_DAY_LAST) ? `TCA_DAY_FIRST : cal_r.day + 3'h1; // see (RL10)
      if (cal_r.date == lastDate) // see (RL11)
      begin
        cal_nxt.date = `TCA_B01;
        monCarry = 1'b1;
      end
      else
        cal_nxt.date = bcdInc(cal_r.date);
      if (monCarry)
      begin
        if (cal_r.month == `TCA_B12) // see (RL9)
        begin
          cal_nxt.month = `TCA_B01;
          yearCarry = 1'b1;
        end
        else
          cal_nxt.month = bcdInc(cal_r.month);
      end
      if (yearCarry)
      begin
        cal_nxt.year = (cal_r.year == `TCA_B99) ? `TCA_B00 : bcdInc(cal_r.year); // see (RL8)
        if (cal_r.year == `TCA_B99)
          cal_nxt.century = bcdInc(cal_r.century); // see (RL7)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Alarm compare: only enabled fields, all at once

  always_comb
  begin
    anyEn = talm_r[`TCA_SECOND_MATCH_ENABLE_BIT] || talm_r[`TCA_MINUTE_MATCH_ENABLE_BIT] || talm_r[`TCA_HOUR_MATCH_ENABLE_BIT] ||
            calm_r[`TCA_MONTH_MATCH_ENABLE_BIT] || calm_r[`TCA_DATE_MATCH_ENABLE_BIT]; // see (RL24)
    alarmMatch = anyEn; // see (RL13)
    if (talm_r[`TCA_SECOND_MATCH_ENABLE_BIT] && (talm_r[`TCA_SEC_RNG] != timeWord[`TCA_SEC_RNG]))
      alarmMatch = 1'b0;
    if (talm_r[`TCA_MINUTE_MATCH_ENABLE_BIT] && (talm_r[`TCA_MIN_RNG] != timeWord[`TCA_MIN_RNG]))
      alarmMatch = 1'b0;
    if (talm_r[`TCA_HOUR_MATCH_ENABLE_BIT] &&
        (talm_r[`TCA_MER_BIT:16] != timeWord[`TCA_MER_BIT:16])) // see (RL15)
      alarmMatch = 1'b0;
    if (calm_r[`TCA_MONTH_MATCH_ENABLE_BIT] && (calm_r[`TCA_MONTH_RNG] != calWord[`TCA_MONTH_RNG])) // see (RL14)
      alarmMatch = 1'b0;
    if (calm_r[`TCA_DATE_MATCH_ENABLE_BIT] && (calm_r[`TCA_DATE_RNG] != calWord[`TCA_DATE_RNG]))
      alarmMatch = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status set and clear; a set in the clearing cycle wins

  always_comb
  begin
    setBits = '0;
    setBits[`TCA_ST_ACK] = secTick && ackPend_r; // see (RL16)
    setBits[`TCA_ST_ALARM] = alarmMatch && !matchPrev_r; // see (RL17)
    setBits[`TCA_ST_SEC] = secTick; // see (RL18)
    unique case (time_event_selector_r) // see (RL21)
      tca_pkg::TEV_MINUTE: setBits[`TCA_ST_TIME_EVENT_FLAG] = minCarry; // see (RL19)
      tca_pkg::TEV_HOUR: setBits[`TCA_ST_TIME_EVENT_FLAG] = hourCarry;
      tca_pkg::TEV_MIDNIGHT: setBits[`TCA_ST_TIME_EVENT_FLAG] = dayCarry;
      tca_pkg::TEV_NOON: setBits[`TCA_ST_TIME_EVENT_FLAG] = noonHit;
    endcase
    unique case (calendar_event_selector_r)
      tca_pkg::CEV_WEEK: setBits[`TCA_ST_CALENDAR_EVENT_FLAG] = dayCarry && !stopCal_r &&
                                                  (cal_nxt.day == `TCA_DAY_WEEK); // see (RL20)
      tca_pkg::CEV_MONTH: setBits[`TCA_ST_CALENDAR_EVENT_FLAG] = monCarry;
      tca_pkg::CEV_YEAR: setBits[`TCA_ST_CALENDAR_EVENT_FLAG] = yearCarry;
      tca_pkg::CEV_RSVD: setBits[`TCA_ST_CALENDAR_EVENT_FLAG] = 1'b0;
    endcase
    clrBits = (wrEn && isReg(paddr, `TCA_OFS_SCLR)) ? pwdata[`TCA_ST_W-1:0] : '0; // see (RL23)
    status_nxt = (status_r & ~clrBits) | setBits;
  end

  // Sticky status flags
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      status_r <= '0; // see (RL12)
    else
      status_r <= status_nxt;
  end

  // Acknowledge waits for the next second boundary after a stop request
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ackPend_r <= 1'b0;
    else if (wrEn && isReg(paddr, `TCA_OFS_MODE) && !(stopTime_r || stopCal_r) &&
             (pwdata[`TCA_STOPT_BIT] || pwdata[`TCA_STOPC_BIT])) // see (RL22)
      ackPend_r <= 1'b1;
    else if (secTick || !(stopTime_r || stopCal_r))
      ackPend_r <= 1'b0;
  end

  // Match history so a standing match raises the flag once
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      matchPrev_r <= 1'b0;
    else
      matchPrev_r <= alarmMatch;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers

  // Mode and hour format
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stopTime_r <= 1'b0;
      stopCal_r <= 1'b0;
      time_event_selector_r <= tca_pkg::TEV_MINUTE;
      calendar_event_selector_r <= tca_pkg::CEV_WEEK;
      hourMode_r <= 1'b0;
    end
    else if (wrEn && isReg(paddr, `TCA_OFS_MODE))
    begin
      stopTime_r <= pwdata[`TCA_STOPT_BIT];
      stopCal_r <= pwdata[`TCA_STOPC_BIT];
      time_event_selector_r <= tca_pkg::tca_tev_t'(pwdata[`TCA_TIME_EVENT_SELECTOR_RNG]);
      calendar_event_selector_r <= tca_pkg::tca_cev_t'(pwdata[`TCA_CALENDAR_EVENT_SELECTOR_RNG]);
    end
    else if (wrEn && isReg(paddr, `TCA_OFS_HMODE))
      hourMode_r <= pwdata[0]; // see (RL1)
  end

  // Time counters; writes land only while time counting is stopped
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      time_r <= '0; // see (RL12)
    else if (wrEn && isReg(paddr, `TCA_OFS_TIME) && stopTime_r) // see (RL22)
    begin
      time_r.second <= {1'b0, pwdata[`TCA_SEC_RNG]};
      time_r.minute <= {1'b0, pwdata[`TCA_MIN_RNG]};
      time_r.hour <= {2'b00, pwdata[`TCA_HOUR_RNG]};
      time_r.meridiem <= pwdata[`TCA_MER_BIT]; // see (RL6)
    end
    else
      time_r <= time_nxt; // see (RL25)
  end

  // Calendar counters; writes land only while calendar counting is stopped
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cal_r.century <= {1'b0, calRst[`TCA_CENTURY_FIELD_RNG]}; // see (RL12)
      cal_r.year <= calRst[`TCA_YEAR_RNG];
      cal_r.month <= {3'b000, calRst[`TCA_MONTH_RNG]};
      cal_r.day <= calRst[`TCA_DAY_RNG];
      cal_r.date <= {2'b00, calRst[`TCA_DATE_RNG]};
    end
    else if (wrEn && isReg(paddr, `TCA_OFS_CAL) && stopCal_r) // see (RL22)
    begin
      cal_r.century <= {1'b0, pwdata[`TCA_CENTURY_FIELD_RNG]};
      cal_r.year <= pwdata[`TCA_YEAR_RNG];
      cal_r.month <= {3'b000, pwdata[`TCA_MONTH_RNG]};
      cal_r.day <= pwdata[`TCA_DAY_RNG];
      cal_r.date <= {2'b00, pwdata[`TCA_DATE_RNG]};
    end
    else
      cal_r <= cal_nxt;
  end

  // Alarm registers; unused bits are stored as zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      talm_r <= `TCA_ZERO32;
      calm_r <= `TCA_ZERO32;
    end
    else if (wrEn && isReg(paddr, `TCA_OFS_TALM))
      talm_r <= {8'h00, pwdata[23:16], pwdata[15:8], pwdata[7:0]};
    else if (wrEn && isReg(paddr, `TCA_OFS_CALM))
      calm_r <= {pwdata[31], 1'b0, pwdata[29:24], pwdata[23], 2'b00, pwdata[20:16], 16'h0000};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB answer: data captured in setup, one access cycle, error off the map

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata_r <= `TCA_ZERO32;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= setupRd;
      pslverr_r <= setupRd && (!known || (paddr[1:0] != 2'b00));
      prdata_r <= `TCA_ZERO32;
      if (setupRd && !pwrite)
      begin
        if (isReg(paddr, `TCA_OFS_MODE))
          prdata_r <= {14'h0000, calendar_event_selector_r, 6'h00, time_event_selector_r, 6'h00, stopCal_r, stopTime_r};
        else if (isReg(paddr, `TCA_OFS_HMODE))
          prdata_r <= {31'h0000_0000, hourMode_r};
        else if (isReg(paddr, `TCA_OFS_TIME))
          prdata_r <= timeWord;
        else if (isReg(paddr, `TCA_OFS_CAL))
          prdata_r <= calWord;
        else if (isReg(paddr, `TCA_OFS_TALM))
          prdata_r <= talm_r;
        else if (isReg(paddr, `TCA_OFS_CALM))
          prdata_r <= calm_r;
        else if (isReg(paddr, `TCA_OFS_STAT))
          prdata_r <= {27'h000_0000, status_r};
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_secWrap;
    secTick && !stopTime_r && !wrEn && time_r.second == `TCA_B59 |=> time_r.second == `TCA_B00;
  endproperty
  a_secWrap: assert property (p_secWrap) else $error("seconds did not wrap"); // see (RL2)

  property p_minStep;
    secTick && !stopTime_r && !wrEn && time_r.second == `TCA_B59 && time_r.minute == `TCA_B09
      |=> time_r.minute == 8'h10;
  endproperty
  a_minStep: assert property (p_minStep) else $error("minute BCD carry wrong"); // see (RL3)

  property p_hour12;
    hourCarry && hourMode_r && !wrEn && time_r.hour == `TCA_B11
      |=> time_r.hour == `TCA_B12 && time_r.meridiem != $past(time_r.meridiem);
  endproperty
  a_hour12: assert property (p_hour12) else $error("12-hour turn wrong"); // see (RL26)

  property p_hold;
    stopTime_r && !wrEn |=> $stable(time_r);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped time moved"); // see (RL25)

  property p_dayWrap;
    dayCarry && !stopCal_r && !wrEn && cal_r.day == `TCA_DAY_LAST |=> cal_r.day == `TCA_DAY_FIRST;
  endproperty
  a_dayWrap: assert property (p_dayWrap) else $error("weekday did not wrap"); // see (RL10)

  property p_secFlag;
    secTick |=> status_r[`TCA_ST_SEC] [*1] ##0 1;
  endproperty
  a_secFlag: assert property (p_secFlag) else $error("second flag missing"); // see (RL18)

  property p_clear;
    wrEn && isReg(paddr, `TCA_OFS_SCLR) && pwdata[`TCA_ST_ALARM] && !setBits[`TCA_ST_ALARM]
      |=> !status_r[`TCA_ST_ALARM];
  endproperty
  a_clear: assert property (p_clear) else $error("alarm flag not cleared"); // see (RL23)

  property p_noEnable;
    !anyEn |=> !$rose(status_r[`TCA_ST_ALARM]);
  endproperty
  a_noEnable: assert property (p_noEnable) else $error("alarm with no field enabled"); // see (RL24)

  property p_ackStopped;
    $rose(status_r[`TCA_ST_ACK]) |-> $past(stopTime_r || stopCal_r);
  endproperty
  a_ackStopped: assert property (p_ackStopped) else $error("acknowledge while counting"); // see (RL16)

  property p_midnight;
    time_event_selector_r == tca_pkg::TEV_MIDNIGHT && dayCarry |=> status_r[`TCA_ST_TIME_EVENT_FLAG];
  endproperty
  a_midnight: assert property (p_midnight) else $error("midnight event lost"); // see (RL19)

  c_alarm: cover property ($rose(status_r[`TCA_ST_ALARM]));
  c_ack: cover property ($rose(status_r[`TCA_ST_ACK]));
  c_year: cover property (yearCarry);
  c_noon: cover property (noonHit && hourMode_r);

endmodule : tca_time_keeper

// [tca_time_keeper_tb.sv]
// Self-checking bench for the APB time, calendar and alarm keeper
`timescale 1ns/1ns
`include "tca_regs.svh"
module tca_time_keeper_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic secTick = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic er;
  logic [31:0] tm;
  logic [31:0] ex;
  int errors = 0;
  int tests_run = 0;
  int seed = 63381;
  int n;
  logic h12;
  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;
  tca_time_keeper uut (.ref_clk(ref_clk), .rst(rst), .secTick(secTick), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  //////////////////////////////////////////////////////////////////////////////////////////
  // Verdict and run end, shared with the watchdog
  task conclude;
    $display("counts: tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  // One APB transfer; held until pready is seen high at a rising edge, the watchdog ends a hang
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp, msg);
  endtask : rchk
  // One-cycle tick, then let the counters settle
  task tick;
    @(posedge ref_clk);
    secTick <= 1'b1;
    @(posedge ref_clk);
    secTick <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : tick
  //////////////////////////////////////////////////////////////////////////////////////////
  // Reference arithmetic
  function automatic logic [31:0] mkTime(logic mer, logic [7:0] h, logic [7:0] m,
    logic [7:0] s);
    return {9'h000, mer, h[5:0], 1'b0, m[6:0], 1'b0, s[6:0]};
  endfunction : mkTime
  function automatic logic [31:0] mkCal(logic [7:0] dt, logic [2:0] dy, logic [7:0] mo,
    logic [7:0] yr, logic [7:0] ce);
    return {2'b00, dt[5:0], dy, mo[4:0], yr, 1'b0, ce[6:0]};
  endfunction : mkCal
  function automatic logic [7:0] bcdInc(logic [7:0] v, logic [7:0] top, logic [7:0] low);
    if (v == top)
      return low;
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcdInc
  function automatic logic [7:0] toBcd(int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : toBcd
  // Seconds to hours; 12-hour form flips meridiem on 11 to 12
  function automatic logic [31:0] advance(logic [31:0] t, logic hm);
    logic [7:0] s;
    logic [7:0] m;
    logic [7:0] h;
    logic mr;
    s = bcdInc({1'b0, t[6:0]}, 8'h59, 8'h00);
    m = {1'b0, t[14:8]};
    h = {2'b00, t[21:16]};
    mr = t[22];
    if (s == 8'h00)
      m = bcdInc(m, 8'h59, 8'h00);
    if (s == 8'h00 && m == 8'h00)
    begin
      mr = (hm && h == 8'h11) ? ~mr : mr;
      h = (hm && h == 8'h11) ? 8'h12 : (hm ? bcdInc(h, 8'h12, 8'h01) : bcdInc(h, 8'h23, 8'h00));
    end
    return mkTime(mr, h, m, s);
  endfunction : advance
  // Stop, await acknowledge, clear flags, load, resume with the given selectors
  task setAll(input logic [31:0] t, input logic [31:0] c, input logic hm, input logic [31:0] sel);
    apb(1'b1, `TCA_OFS_HMODE, {31'h0000_0000, hm});
    apb(1'b1, `TCA_OFS_MODE, 32'h0000_0003);
    tick;
    apb(1'b0, `TCA_OFS_STAT, 32'h0000_0000);
    check({31'h0000_0000, rd[0]}, 32'h0000_0001, "ack");
    apb(1'b1, `TCA_OFS_SCLR, 32'h0000_001F);
    rchk(`TCA_OFS_STAT, 32'h0000_0000, "clear all");
    apb(1'b1, `TCA_OFS_TIME, t);
    apb(1'b1, `TCA_OFS_CAL, c);
    apb(1'b1, `TCA_OFS_MODE, sel);
  endtask : setAll
  //////////////////////////////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the 1300 or fewer cycles the tests need
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    conclude;
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rchk(8'(i * 4), (i == 3) ? `TCA_CAL_RST : `TCA_ZERO32, "reset value");
    apb(1'b0, 8'h20, 32'h0000_0000);
    check({31'h0000_0000, er}, 32'h0000_0001, "unmapped");
    apb(1'b0, 8'h06, 32'h0000_0000);
    check({31'h0000_0000, er}, 32'h0000_0001, "unaligned");
    apb(1'b1, `TCA_OFS_TIME, 32'h0012_3456);
    apb(1'b1, `TCA_OFS_CAL, 32'h1234_5678);
    apb(1'b1, `TCA_OFS_STAT, 32'h0000_001F);
    rchk(`TCA_OFS_TIME, 32'h0000_0000, "time write unstopped");
    rchk(`TCA_OFS_CAL, `TCA_CAL_RST, "cal write unstopped");
    rchk(`TCA_OFS_STAT, 32'h0000_0000, "status read-only");
    apb(1'b1, `TCA_OFS_HMODE, 32'h0000_0001);
    rchk(`TCA_OFS_HMODE, 32'h0000_0001, "hour format");
    $display("test reset and access done");
    // Time selectors across noon and midnight; midnight never at 11:59:59
    for (int k = 0; k < 8; k++)
    begin
      tm = mkTime(1'b0, (k < 4) ? 8'h11 : 8'h23, 8'h59, 8'h59);
      setAll(tm, mkCal(8'h15, 3'h3, 8'h06, 8'h24, 8'h20), 1'b0, 32'(k % 4) << 8);
      tick;
      ex = {27'h0, 1'b0, (k < 4) ? (k != 2) : (k != 7), 3'b100};
      rchk(`TCA_OFS_STAT, ex, "time event");
      rchk(`TCA_OFS_TIME, advance(tm, 1'b0), "24h carry");
    end
    $display("test time events done");
    // Calendar selectors on the century rollover; reserved code raises nothing
    for (int k = 0; k < 4; k++)
    begin
      setAll(mkTime(1'b0, 8'h23, 8'h59, 8'h59), mkCal(8'h31, 3'h7, 8'h12, 8'h99, 8'h19), 1'b0,
        32'(k) << 16);
      tick;
      rchk(`TCA_OFS_STAT, {27'h0, k != 3, 4'b1100}, "cal event");
      rchk(`TCA_OFS_CAL, mkCal(8'h01, 3'h1, 8'h01, 8'h00, 8'h20), "rollover");
    end
    // Leap and common February
    for (int k = 0; k < 2; k++)
    begin
      setAll(mkTime(1'b0, 8'h23, 8'h59, 8'h59), mkCal(8'h28, 3'h2, 8'h02, 8'(k), 8'h20), 1'b0,
        32'h0000_0000);
      tick;
      ex = k ? mkCal(8'h01, 3'h3, 8'h03, 8'h01, 8'h20) : mkCal(8'h29, 3'h3, 8'h02, 8'h00, 8'h20);
      rchk(`TCA_OFS_CAL, ex, "february");
    end
    $display("test calendar done");
    // 12-hour corners, then random times in both formats
    for (int i = 0; i < 12; i++)
    begin
      h12 = (i < 3) ? 1'b1 : 1'($random(seed));
      n = $unsigned($random(seed)) % 24;
      tm = mkTime(h12 & 1'($random(seed)), h12 ? toBcd(n % 12 + 1) : toBcd(n),
        toBcd($unsigned($random(seed)) % 60), toBcd(57 + $unsigned($random(seed)) % 3));
      tm = (i < 3) ? mkTime(i == 2, (i == 1) ? 8'h12 : 8'h11, 8'h59, 8'h59) : tm;
      setAll(tm, `TCA_CAL_RST, h12, 32'h0000_0000);
      n = 1 + $unsigned($random(seed)) % 3;
      repeat (n)
      begin
        tick;
        tm = advance(tm, h12);
      end
      rchk(`TCA_OFS_TIME, tm, "time count");
    end
    $display("test random time done");
    // Alarms: none enabled, partial mismatch, full match, then calendar fields
    setAll(mkTime(1'b0, 8'h08, 8'h30, 8'h10), mkCal(8'h15, 3'h3, 8'h06, 8'h24, 8'h20), 1'b0,
      32'h0000_0000);
    tick;
    rchk(`TCA_OFS_STAT, 32'h0000_0004, "no enables");
    apb(1'b1, `TCA_OFS_TALM, {16'h0000, 1'b1, 7'h31, 1'b1, 7'h12});
    tick;
    rchk(`TCA_OFS_STAT, 32'h0000_0004, "minute mismatch");
    apb(1'b1, `TCA_OFS_TALM, {8'h00, 1'b1, 1'b0, 6'h08, 1'b1, 7'h30, 1'b1, 7'h13});
    rchk(`TCA_OFS_TALM, 32'h0088_B093, "alarm readback");
    tick;
    rchk(`TCA_OFS_STAT, 32'h0000_0006, "full match");
    apb(1'b1, `TCA_OFS_SCLR, 32'h0000_0000);
    rchk(`TCA_OFS_STAT, 32'h0000_0006, "zero clear");
    apb(1'b1, `TCA_OFS_SCLR, 32'h0000_0006);
    rchk(`TCA_OFS_STAT, 32'h0000_0000, "one clear");
    apb(1'b1, `TCA_OFS_TALM, 32'h0000_0000);
    apb(1'b1, `TCA_OFS_CALM, 32'h9586_0000);
    tick;
    rchk(`TCA_OFS_STAT, 32'h0000_0006, "date match");
    apb(1'b1, `TCA_OFS_SCLR, 32'h0000_0006);
    apb(1'b1, `TCA_OFS_CALM, 32'h9587_0000);
    tick;
    rchk(`TCA_OFS_STAT, 32'h0000_0004, "month mismatch");
    $display("test alarms done");
    conclude;
  end
endmodule : tca_time_keeper_tb
